// ---- flash_pkg.sv ----
// constants, opcodes and state encoding for the quad spi flash sequencer
package flash_pkg;

    // ------------------------------------------------------------
    // clock and self-timed cycle lengths
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int PROGRAM_CYCLE_TIME_US = 1000;
    localparam int SECTOR_ERASE_TIME_US = 50000;
    localparam int HALF_BLOCK_ERASE_TIME_US = 100000;
    localparam int PROGRAM_CYCLE_CYCLES = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
    localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int HALF_BLOCK_ERASE_CYCLES = HALF_BLOCK_ERASE_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 24;

    // ------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS_1 = 8'h05;
    localparam logic [7:0] OP_READ_STATUS_2 = 8'h35;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_DATA_PROGRAM = 8'h32;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_MODE_BIT_RESET = 8'hff;

    // ------------------------------------------------------------
    // frame geometry and array layout
    // ------------------------------------------------------------
    localparam logic [3:0] CONT_READ_NIBBLE = 4'ha;
    localparam logic [4:0] CMD_LAST_CLK = 5'h07;
    localparam logic [4:0] ADDR_LAST_CLK_SINGLE = 5'h17;
    localparam logic [4:0] ADDR_LAST_CLK_QUAD = 5'h05;
    localparam logic [4:0] MODE_LAST_CLK = 5'h01;
    localparam logic [4:0] DUMMY_LAST_CLK = 5'h03;
    localparam logic [4:0] BYTE_LAST_CLK_SINGLE = 5'h07;
    localparam logic [4:0] BYTE_LAST_CLK_QUAD = 5'h01;
    localparam int PAGE_LOG2 = 8;
    localparam int SECTOR_LOG2 = 12;
    localparam int HALF_BLOCK_LOG2 = 15;
    localparam int BLOCK_LOG2 = 16;
    localparam int CAPACITY_LOG2_DEFAULT = 22;

    // ------------------------------------------------------------
    // status register bit positions (second register holds bit 9 as bit 1)
    // ------------------------------------------------------------
    localparam int SR1_BUSY_POS = 0;
    localparam int SR1_WEL_POS = 1;
    localparam int SR1_BP0_POS = 2;
    localparam int SR1_TB_POS = 5;
    localparam int SR1_SEC_POS = 6;
    localparam int SR2_QE_POS = 1;

    // pin synchroniser reset level: chip select idles high
    localparam logic [5:0] PIN_RESET = 6'h20;

    // ------------------------------------------------------------
    // frame decoder states
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_CMD = 10'h002,
        ST_ADDR = 10'h004,
        ST_MODE = 10'h008,
        ST_DUMMY = 10'h010,
        ST_RDATA = 10'h020,
        ST_WDATA = 10'h040,
        ST_STATUS = 10'h080,
        ST_ARMED = 10'h100,
        ST_IGNORE = 10'h200
    } frame_state_t;

endpackage

// ---- quad_spi_flash_seq.sv ----
// quad spi flash command sequencer: quad read, page program, sector and half block erase
`timescale 1ns/10ps
module quad_spi_flash_seq
    import flash_pkg::*;
#(
    parameter int PROGRAM_CYCLES = PROGRAM_CYCLE_CYCLES,
    parameter int SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
    parameter int HALF_BLOCK_CYCLES = HALF_BLOCK_ERASE_CYCLES,
    parameter int CAPACITY_LOG2 = CAPACITY_LOG2_DEFAULT
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic SPI_CLOCK,
    input wire logic CHIP_SELECT_N,
    input wire logic [3:0] QUAD_LINE_IN,
    output logic [3:0] QUAD_LINE_OUT,
    output logic [3:0] QUAD_LINE_OE,
    input wire logic QUAD_ENABLE_BIT,
    input wire logic PROTECT_GRANULARITY_BIT,
    input wire logic PROTECT_TOP_BOTTOM_BIT,
    input wire logic PROTECT_RANGE_BIT_2,
    input wire logic PROTECT_RANGE_BIT_1,
    input wire logic PROTECT_RANGE_BIT_0,
    output logic BUSY,
    output logic WRITE_ENABLE_LATCH,
    output logic CONTINUOUS_READ_ACTIVE,
    output logic [23:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WRITE,
    input wire logic [7:0] MEM_RDATA
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] s1_q, s2_q, s3_q, filt_q;
    logic cs_prev_q, sclk_prev_q;
    logic cs_n, sclk, cs_rise, cs_fall, sclk_rise, sclk_fall;
    logic [3:0] io_in;

    assign pin_raw = {CHIP_SELECT_N, SPI_CLOCK, QUAD_LINE_IN};

    // three stages; a level is taken once the second and third agree
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            s1_q <= PIN_RESET;
            s2_q <= PIN_RESET;
            s3_q <= PIN_RESET;
            filt_q <= PIN_RESET;
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (filt_q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
            cs_prev_q <= filt_q[5];
            sclk_prev_q <= filt_q[4];
        end
    end

    assign cs_n = filt_q[5];
    assign sclk = filt_q[4];
    assign io_in = filt_q[3:0];
    assign cs_rise = cs_n & ~cs_prev_q;
    assign cs_fall = ~cs_n & cs_prev_q;
    assign sclk_rise = sclk & ~sclk_prev_q & ~cs_n;
    assign sclk_fall = ~sclk & sclk_prev_q & ~cs_n;

    // ------------------------------------------------------------
    // frame decoder
    // ------------------------------------------------------------
    frame_state_t state_q;
    logic [4:0] cnt_q;
    logic [4:0] last_cnt;
    logic [7:0] cmd_q, byte_q, byte_d, opc;
    logic [23:0] addr_q, addr_d;
    logic addr_quad_q, data_quad_q, lane_quad, phase_end;
    logic busy_q, wel_q, cont_q, exec_done;
    logic cmd_done, addr_done, mode_done, byte_done;
    logic is_program, is_erase;

    assign lane_quad = (state_q == ST_ADDR && addr_quad_q) || state_q == ST_MODE ||
                       (state_q == ST_WDATA && data_quad_q);
    assign byte_d = lane_quad ? {byte_q[3:0], io_in} : {byte_q[6:0], io_in[0]};
    assign addr_d = addr_quad_q ? {addr_q[19:0], io_in} : {addr_q[22:0], io_in[0]};
    assign opc = byte_d;
    assign is_program = cmd_q == OP_PAGE_PROGRAM || cmd_q == OP_QUAD_DATA_PROGRAM ||
                        cmd_q == OP_QUAD_PAGE_PROGRAM;
    assign is_erase = cmd_q == OP_SECTOR_ERASE || cmd_q == OP_HALF_BLOCK_ERASE;

    // clock count that closes the current phase
    always_comb begin
        last_cnt = CMD_LAST_CLK;
        unique case (state_q)
            ST_ADDR: last_cnt = addr_quad_q ? ADDR_LAST_CLK_QUAD : ADDR_LAST_CLK_SINGLE;
            ST_MODE: last_cnt = MODE_LAST_CLK;
            ST_DUMMY: last_cnt = DUMMY_LAST_CLK;
            ST_WDATA: last_cnt = data_quad_q ? BYTE_LAST_CLK_QUAD : BYTE_LAST_CLK_SINGLE;
            ST_IDLE, ST_CMD, ST_RDATA, ST_STATUS, ST_ARMED, ST_IGNORE: last_cnt = CMD_LAST_CLK;
        endcase
    end

    assign phase_end = sclk_rise && cnt_q == last_cnt;
    assign cmd_done = phase_end && state_q == ST_CMD;
    assign addr_done = phase_end && state_q == ST_ADDR;
    assign mode_done = phase_end && state_q == ST_MODE;
    assign byte_done = phase_end && state_q == ST_WDATA;

    // phase sequencing on each filtered serial clock rise
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            cmd_q <= 8'h00;
            byte_q <= 8'h00;
            addr_q <= 24'h000000;
            addr_quad_q <= 1'b0;
            data_quad_q <= 1'b0;
        end else if (cs_rise) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
        end else if (cs_fall) begin
            cnt_q <= 5'h00;
            byte_q <= 8'h00;
            if (cont_q) begin
                cmd_q <= OP_QUAD_IO_READ;
                addr_quad_q <= 1'b1;
                state_q <= (busy_q || !QUAD_ENABLE_BIT) ? ST_IGNORE : ST_ADDR;
            end else begin
                state_q <= ST_CMD;
            end
        end else if (sclk_rise) begin
            cnt_q <= phase_end ? 5'h00 : cnt_q + 5'h01;
            byte_q <= byte_d;
            unique case (state_q)
                ST_CMD: begin
                    if (cmd_done) begin
                        cmd_q <= opc;
                        addr_quad_q <= opc == OP_QUAD_IO_READ || opc == OP_QUAD_PAGE_PROGRAM;
                        data_quad_q <= opc != OP_PAGE_PROGRAM;
                        state_q <= ST_IGNORE;
                        if (opc == OP_READ_STATUS_1 || opc == OP_READ_STATUS_2) begin
                            state_q <= ST_STATUS;
                        end else if (busy_q) begin
                            state_q <= ST_IGNORE;
                        end else if (opc == OP_QUAD_IO_READ) begin
                            state_q <= QUAD_ENABLE_BIT ? ST_ADDR : ST_IGNORE;
                        end else if (opc == OP_PAGE_PROGRAM || is_erase_op(opc)) begin
                            state_q <= wel_q ? ST_ADDR : ST_IGNORE;
                        end else if (opc == OP_QUAD_DATA_PROGRAM ||
                                     opc == OP_QUAD_PAGE_PROGRAM) begin
                            state_q <= (wel_q && QUAD_ENABLE_BIT) ? ST_ADDR : ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_q <= addr_d;
                    if (addr_done) begin
                        if (cmd_q == OP_QUAD_IO_READ) begin
                            state_q <= ST_MODE;
                        end else if (is_program) begin
                            state_q <= ST_WDATA;
                        end else begin
                            state_q <= ST_ARMED;
                        end
                    end
                end
                ST_MODE: state_q <= mode_done ? ST_DUMMY : ST_MODE;
                ST_DUMMY: state_q <= phase_end ? ST_RDATA : ST_DUMMY;
                ST_ARMED: state_q <= ST_IGNORE;
                ST_IDLE, ST_RDATA, ST_WDATA, ST_STATUS, ST_IGNORE: state_q <= state_q;
            endcase
        end
    end

    function automatic logic is_erase_op(input logic [7:0] op);
        is_erase_op = op == OP_SECTOR_ERASE || op == OP_HALF_BLOCK_ERASE;
    endfunction

    // write enable latch: set by command, cleared when a cycle ends
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wel_q <= 1'b0;
        end else if (exec_done) begin
            wel_q <= 1'b0;
        end else if (cmd_done && !busy_q && opc == OP_WRITE_ENABLE) begin
            wel_q <= 1'b1;
        end else if (cmd_done && !busy_q && opc == OP_WRITE_DISABLE) begin
            wel_q <= 1'b0;
        end
    end

    // continuous read mode, kept across frames
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cont_q <= 1'b0;
        end else if (cmd_done && opc == OP_MODE_BIT_RESET) begin
            cont_q <= 1'b0;
        end else if (mode_done) begin
            cont_q <= byte_d[7:4] == CONT_READ_NIBBLE;
        end
    end

    // ------------------------------------------------------------
    // page buffer
    // ------------------------------------------------------------
    logic [7:0] page_mem [0:255];
    logic [255:0] page_valid_q;
    logic [7:0] page_ptr_q;
    logic have_byte_q;

    // pointer wraps inside the page so only the last 256 bytes survive
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            page_valid_q <= 256'h0;
            page_ptr_q <= 8'h00;
            have_byte_q <= 1'b0;
        end else if (addr_done && is_program) begin
            page_valid_q <= 256'h0;
            page_ptr_q <= addr_d[7:0];
            have_byte_q <= 1'b0;
        end else if (byte_done) begin
            page_valid_q[page_ptr_q] <= 1'b1;
            page_ptr_q <= page_ptr_q + 8'h01;
            have_byte_q <= 1'b1;
        end
    end

    // byte storage, no reset needed
    always_ff @(posedge MCLK) begin
        if (byte_done) begin
            page_mem[page_ptr_q] <= byte_d;
        end
    end

    // ------------------------------------------------------------
    // protection and start of self-timed cycles
    // ------------------------------------------------------------
    logic [2:0] bp;
    logic prog_start, erase_start;
    logic [4:0] erase_log2;

    assign bp = {PROTECT_RANGE_BIT_2, PROTECT_RANGE_BIT_1, PROTECT_RANGE_BIT_0};
    assign erase_log2 = cmd_q == OP_SECTOR_ERASE ? 5'(SECTOR_LOG2) : 5'(HALF_BLOCK_LOG2);

    // true when [aligned a, +2^span) overlaps the protected range
    function automatic logic hits_protect(input logic [23:0] a, input logic [4:0] span);
        logic [31:0] cap, psize, first, last;
        logic [4:0] plog;
        cap = 32'h1 << CAPACITY_LOG2;
        plog = 5'(CAPACITY_LOG2);
        if (PROTECT_GRANULARITY_BIT) begin
            plog = bp >= 3'h5 ? 5'(HALF_BLOCK_LOG2) : 5'(SECTOR_LOG2 - 1) + 5'(bp);
        end else if (bp < 3'h6) begin
            plog = 5'(BLOCK_LOG2 - 1) + 5'(bp);
        end
        psize = 32'h1 << plog;
        first = {8'h00, a} & (cap - 32'h1) & ~((32'h1 << span) - 32'h1);
        last = first + (32'h1 << span);
        if (bp == 3'h0) begin
            hits_protect = 1'b0;
        end else if (PROTECT_TOP_BOTTOM_BIT) begin
            hits_protect = first < psize;
        end else begin
            hits_protect = last > cap - psize;
        end
    endfunction

    assign prog_start = cs_rise && state_q == ST_WDATA && cnt_q == 5'h00 && have_byte_q &&
                        !hits_protect(addr_q, 5'(PAGE_LOG2));
    assign erase_start = cs_rise && state_q == ST_ARMED && is_erase &&
                         !hits_protect(addr_q, erase_log2);

    // ------------------------------------------------------------
    // self-timed engine and array port
    // ------------------------------------------------------------
    logic [TIMER_W-1:0] timer_q;
    logic wr_active_q, erase_run_q;
    logic [1:0] wr_phase_q;
    logic [15:0] wr_idx_q, wr_last_q;
    logic [23:0] wr_base_q, rd_addr_q;

    assign exec_done = busy_q && !wr_active_q && timer_q == '0;

    // busy lasts the cycle time and at least until every array write is done
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_q <= 1'b0;
            timer_q <= '0;
            wr_active_q <= 1'b0;
            erase_run_q <= 1'b0;
            wr_phase_q <= 2'h0;
            wr_idx_q <= 16'h0000;
            wr_last_q <= 16'h0000;
            wr_base_q <= 24'h000000;
            MEM_ADDR <= 24'h000000;
            MEM_WDATA <= 8'h00;
            MEM_WRITE <= 1'b0;
        end else if (prog_start || erase_start) begin
            busy_q <= 1'b1;
            wr_active_q <= 1'b1;
            erase_run_q <= erase_start;
            wr_phase_q <= 2'h0;
            wr_idx_q <= 16'h0000;
            MEM_WRITE <= 1'b0;
            if (prog_start) begin
                timer_q <= TIMER_W'(PROGRAM_CYCLES - 1);
                wr_last_q <= 16'h00ff;
                wr_base_q <= {addr_q[23:8], 8'h00};
            end else if (cmd_q == OP_SECTOR_ERASE) begin
                timer_q <= TIMER_W'(SECTOR_CYCLES - 1);
                wr_last_q <= 16'h0fff;
                wr_base_q <= {addr_q[23:12], 12'h000};
            end else begin
                timer_q <= TIMER_W'(HALF_BLOCK_CYCLES - 1);
                wr_last_q <= 16'h7fff;
                wr_base_q <= {addr_q[23:15], 15'h0000};
            end
        end else if (busy_q) begin
            MEM_WRITE <= 1'b0;
            if (timer_q != '0) begin
                timer_q <= timer_q - TIMER_W'(1);
            end
            if (exec_done) begin
                busy_q <= 1'b0;
            end
            if (wr_active_q && erase_run_q) begin
                MEM_ADDR <= wr_base_q | {8'h00, wr_idx_q};
                MEM_WDATA <= 8'hff;
                MEM_WRITE <= 1'b1;
                wr_idx_q <= wr_idx_q + 16'h0001;
                wr_active_q <= wr_idx_q != wr_last_q;
            end else if (wr_active_q && !page_valid_q[wr_idx_q[7:0]]) begin
                wr_idx_q <= wr_idx_q + 16'h0001;
                wr_active_q <= wr_idx_q != wr_last_q;
            end else if (wr_active_q) begin
                MEM_ADDR <= wr_base_q | {8'h00, wr_idx_q};
                wr_phase_q <= wr_phase_q == 2'h2 ? 2'h0 : wr_phase_q + 2'h1;
                if (wr_phase_q == 2'h2) begin
                    MEM_WDATA <= MEM_RDATA & page_mem[wr_idx_q[7:0]];
                    MEM_WRITE <= 1'b1;
                    wr_idx_q <= wr_idx_q + 16'h0001;
                    wr_active_q <= wr_idx_q != wr_last_q;
                end
            end
        end else begin
            MEM_WRITE <= 1'b0;
            MEM_ADDR <= rd_addr_q; // read path only while idle
        end
    end

    // ------------------------------------------------------------
    // output lines: read data and status shift out on falling edges
    // ------------------------------------------------------------
    logic nib_hi_q;
    logic [7:0] stat_q;
    logic [7:0] sr1, sr2;

    // status words, widened before shifting so no flag is lost
    assign sr1 = (8'(busy_q) << SR1_BUSY_POS) | (8'(wel_q) << SR1_WEL_POS) |
                 (8'(bp) << SR1_BP0_POS) | (8'(PROTECT_TOP_BOTTOM_BIT) << SR1_TB_POS) |
                 (8'(PROTECT_GRANULARITY_BIT) << SR1_SEC_POS);
    assign sr2 = 8'(QUAD_ENABLE_BIT) << SR2_QE_POS;

    // line drivers, status snapshot and read address per falling edge
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            QUAD_LINE_OUT <= 4'h0;
            QUAD_LINE_OE <= 4'h0;
            nib_hi_q <= 1'b1;
            stat_q <= 8'h00;
            rd_addr_q <= 24'h000000;
        end else if (cs_n) begin
            QUAD_LINE_OUT <= 4'h0;
            QUAD_LINE_OE <= 4'h0;
            nib_hi_q <= 1'b1;
        end else if (cmd_done) begin
            stat_q <= opc == OP_READ_STATUS_2 ? sr2 : sr1;
        end else if (mode_done) begin
            rd_addr_q <= addr_q; // address already complete
            nib_hi_q <= 1'b1;
        end else if (sclk_fall && state_q == ST_RDATA) begin
            QUAD_LINE_OUT <= nib_hi_q ? MEM_RDATA[7:4] : MEM_RDATA[3:0];
            QUAD_LINE_OE <= 4'hf;
            nib_hi_q <= ~nib_hi_q;
            if (!nib_hi_q) begin
                rd_addr_q <= rd_addr_q + 24'h000001;
            end
        end else if (sclk_fall && state_q == ST_STATUS) begin
            QUAD_LINE_OUT <= {2'b00, stat_q[7], 1'b0};
            QUAD_LINE_OE <= 4'h2;
            stat_q <= {stat_q[6:0], stat_q[7]};
        end
    end

    assign BUSY = busy_q;
    assign WRITE_ENABLE_LATCH = wel_q;
    assign CONTINUOUS_READ_ACTIVE = cont_q;

endmodule

// ---- flash_asserts.sv ----
// assertion checker for the flash sequencer ports
`timescale 1ns/10ps
module flash_asserts (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic CHIP_SELECT_N,
    input wire logic QUAD_ENABLE_BIT,
    input wire logic [3:0] QUAD_LINE_OE,
    input wire logic BUSY,
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic CONTINUOUS_READ_ACTIVE,
    input wire logic MEM_WRITE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    // start of a self-timed cycle
    sequence busy_start_s; !BUSY ##1 BUSY; endsequence
    write_in_busy_a: assert property (MEM_WRITE |-> BUSY)
        else $error("array write outside busy");
    start_needs_wel_a: assert property (busy_start_s |-> WRITE_ENABLE_LATCH)
        else $error("cycle started without latch");
    start_after_cs_a: assert property (busy_start_s |-> CHIP_SELECT_N && $past(CHIP_SELECT_N, 3))
        else $error("cycle started inside a frame");
    end_clears_wel_a: assert property ($fell(BUSY) |-> ##[0:1] !WRITE_ENABLE_LATCH)
        else $error("latch kept after cycle");
    oe_legal_a: assert property (QUAD_LINE_OE inside {4'h0, 4'h2, 4'hf})
        else $error("odd enable pattern");
    idle_no_oe_a: assert property (CHIP_SELECT_N [*8] |-> QUAD_LINE_OE == 4'h0)
        else $error("lines driven while deselected");
    busy_no_read_a: assert property (BUSY |-> QUAD_LINE_OE != 4'hf)
        else $error("read data while busy");
    cont_needs_qe_a: assert property ($rose(CONTINUOUS_READ_ACTIVE) |-> QUAD_ENABLE_BIT && !BUSY)
        else $error("continuous mode without quad enable");
endmodule
bind quad_spi_flash_seq flash_asserts flash_asserts_inst (.MCLK, .RESETN, .CHIP_SELECT_N,
    .QUAD_ENABLE_BIT, .QUAD_LINE_OE, .BUSY, .WRITE_ENABLE_LATCH, .CONTINUOUS_READ_ACTIVE, .MEM_WRITE);

// ---- spi_host_model.sv ----
// spi host model driving clock, select and the four lines
`timescale 1ns/10ps
module spi_host_model (
    input wire logic mclk,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] lines
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        lines = 4'h0;
    end
    // select stays low for the whole frame
    task automatic start(); @(posedge mclk); cs_n <= 1'b0; endtask
    // release lines with inverted value so stale data is never seen
    task automatic stop();
        repeat (4) @(posedge mclk);
        cs_n <= 1'b1;
        lines <= ~lines;
        repeat (12) @(posedge mclk);
    endtask
    // msb first, four mclk per half period
    task automatic shift(input logic [31:0] v, input int n, input int w);
        for (int i = 0; i < n; i++) begin
            if (w == 4) lines <= v[31-4*i -: 4];
            else lines[0] <= v[31-i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            sclk <= 1'b0;
        end
    endtask
endmodule

// ---- tb_quad_spi_flash_program_erase.sv ----
// self-checking bench for the quad spi flash sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_quad_spi_flash_program_erase;
    import flash_pkg::*;
    logic mclk, resetn, qe, busy, write_enable_latch, cra, mem_write, sclk, cs_n;
    logic [3:0] line_out, line_oe, lines;
    logic [4:0] prot;
    logic [23:0] mem_addr;
    logic [7:0] mem_wdata, rdata, lfsr_q;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v;
    int fail_count, checks;
    spi_host_model h (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .lines(lines));
    quad_spi_flash_seq #(.PROGRAM_CYCLES(600), .SECTOR_CYCLES(5000), .HALF_BLOCK_CYCLES(33000))
    quad_spi_flash_seq_inst (.MCLK(mclk), .RESETN(resetn), .SPI_CLOCK(sclk),
        .CHIP_SELECT_N(cs_n), .QUAD_LINE_IN(lines), .QUAD_LINE_OUT(line_out),
        .QUAD_LINE_OE(line_oe), .QUAD_ENABLE_BIT(qe), .PROTECT_GRANULARITY_BIT(prot[4]),
        .PROTECT_TOP_BOTTOM_BIT(prot[3]), .PROTECT_RANGE_BIT_2(prot[2]),
        .PROTECT_RANGE_BIT_1(prot[1]), .PROTECT_RANGE_BIT_0(prot[0]), .BUSY(busy),
        .WRITE_ENABLE_LATCH(write_enable_latch), .CONTINUOUS_READ_ACTIVE(cra), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_WRITE(mem_write), .MEM_RDATA(rdata));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // each array write takes the oldest expected note
    always @(posedge mclk) if (mem_write === 1'b1) begin
        if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
        else begin
            exp_v = exp_q.pop_front();
            `CHK({mem_addr, mem_wdata}, exp_v)
        end
    end
    // next value of the stimulus shift register
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic final_report();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // frame: opcode, address, n data bytes, x stray clocks; e notes the writes
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n, input int x,
            input bit e);
        bit q;
        q = (op == OP_QUAD_PAGE_PROGRAM);
        h.start();
        h.shift({op, 24'h0}, 8, 1);
        if (op != OP_WRITE_ENABLE) h.shift({a, 8'h0}, q ? 6 : 24, q ? 4 : 1);
        for (int i = 0; i < n; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            if (e && i > 255) exp_q[i-256] = {a + 24'(i - 256), lfsr_q & rdata};
            else if (e) exp_q.push_back({a + 24'(i), lfsr_q & rdata});
            h.shift({lfsr_q, 24'h0}, op == OP_PAGE_PROGRAM ? 8 : 2, op == OP_PAGE_PROGRAM ? 1 : 4);
        end
        h.shift(32'h0, x, 1);
        h.stop();
    endtask
    // busy on start, then bounded wait for the self-timed end
    task automatic done(input logic eb, input logic ew);
        `CHK(busy, eb)
        for (int i = 0; i < 40000 && busy !== 1'b0; i++) @(posedge mclk);
        if (busy !== 1'b0) begin `CHK(busy, 1'b0) final_report(); end
        `CHK({write_enable_latch, 31'(exp_q.size())}, {ew, 31'h0})
    endtask
    // main sequence
    initial begin
        resetn = 1'b0; qe = 1'b0; prot = 5'h00; rdata = 8'h6c; lfsr_q = 8'h1c;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        repeat (8) @(posedge mclk);
        `CHK({busy, write_enable_latch}, 2'b00)
        prog(OP_WRITE_ENABLE, 0, 0, 0, 0);
        `CHK(write_enable_latch, 1'b1)
        prog(OP_PAGE_PROGRAM, 24'h000110, 3, 0, 1); done(1'b1, 1'b0);
        prog(OP_PAGE_PROGRAM, 24'h000120, 1, 0, 0); done(1'b0, 1'b0);
        prog(OP_WRITE_ENABLE, 0, 0, 0, 0);
        prot <= 5'h01;
        prog(OP_PAGE_PROGRAM, 24'h3fff00, 1, 0, 0); done(1'b0, 1'b1);
        prot <= 5'h00;
        prog(OP_QUAD_PAGE_PROGRAM, 24'h000200, 1, 0, 0); done(1'b0, 1'b1);
        prog(OP_PAGE_PROGRAM, 24'h000130, 1, 3, 0); done(1'b0, 1'b1);
        prog(OP_SECTOR_ERASE, 24'h002000, 0, 1, 0); done(1'b0, 1'b1);
        prog(OP_WRITE_DISABLE, 0, 0, 0, 0);
        `CHK(write_enable_latch, 1'b0)
        prog(OP_WRITE_ENABLE, 0, 0, 0, 0);
        qe <= 1'b1;
        prog(OP_QUAD_PAGE_PROGRAM, 24'h000200, 2, 0, 1); done(1'b1, 1'b0);
        prog(OP_WRITE_ENABLE, 0, 0, 0, 0);
        // full page from a zero low address byte, two bytes beyond the page
        prog(OP_QUAD_DATA_PROGRAM, 24'h000300, 258, 0, 1);
        done(1'b1, 1'b0);
        for (int i = 0; i < 4096; i++) exp_q.push_back({24'h001000 + 24'(i), 8'hff});
        prog(OP_WRITE_ENABLE, 0, 0, 0, 0);
        prog(OP_SECTOR_ERASE, 24'h001234, 0, 0, 0);
        h.start();
        h.shift({OP_READ_STATUS_1, 24'h0}, 16, 1);
        `CHK({line_oe, line_out}, {4'h2, 4'h2})
        h.stop();
        done(1'b1, 1'b0);
        for (int i = 0; i < 32768; i++) exp_q.push_back({24'h008000 + 24'(i), 8'hff});
        prog(OP_WRITE_ENABLE, 0, 0, 0, 0);
        prog(OP_HALF_BLOCK_ERASE, 24'h00c000, 0, 0, 0); done(1'b1, 1'b0);
        for (int m = 0; m < 2; m++) begin
            h.start();
            if (m == 0) h.shift({OP_QUAD_IO_READ, 24'h0}, 8, 1);
            h.shift({24'h000400, m ? 8'h05 : 8'ha5}, 8, 4);
            h.shift(32'h0, 6, 4);
            `CHK({line_oe, line_out}, {4'hf, rdata[3:0]})
            h.stop();
            `CHK(cra, m == 0)
        end
        final_report();
    end
endmodule
